// File: pmcd_top.sv
// power mode control, economy divider, oscillator select and switchback
//
// Overview of operation
// - writing one to idle bit enters idle after that write
// - idle stops core clock enable, peripherals keep ticking
// - idle drives address strobe and program strobe high, ports hold
// - any enabled interrupt in idle clears idle bit and resumes core
// - external reset high eight clocks resets; execution restarts at once
// - reset exit from idle never runs the following instruction
// - watchdog time-out raises interrupt; reset after 512 clocks if uncleared
// - divide field bits 7:6 select 4, 64 or 1024 clocks per cycle
// - economy slows peripherals too; idle peripherals run at clock over four
// - new divide setting applies after one machine cycle
// - source select picks crystal or RC; indicator shows applied source
// - crystal ready flag set by hardware; crystal select refused until set
// - with switchback enabled, serial or external interrupt forces divide four
// - start bit falling edge or buffer write triggers switchback
// - switchback ignores serial flags; software may rewrite divide field later
// - divide field writes ignored while switchback enabled and serial busy
// - every reset source forces divide by four
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pmcd_top
    import pmcd_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic [7:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    input  wire logic            ext_rst_pin,
    input  wire logic            irq_wake,
    input  wire logic            ext_int_ack,
    input  wire logic            wdt_timeout,
    input  wire logic            wdt_clear,
    input  wire logic            crystal_warm,
    input  wire pmcd_serial_type ser,
    input  wire logic            ale_core,
    input  wire logic            pstore_core,
    output logic                 core_clk_en,
    output logic                 mc_tick,
    output logic                 periph_tick,
    output logic                 addr_latch_strobe,
    output logic                 program_store_strobe,
    output logic                 port_hold,
    output logic                 osc_xtal_active,
    output logic                 crystal_amp_disable,
    output logic                 wdt_irq,
    output logic                 sys_rst
);

    function automatic logic [9:0] div_mask(input logic [1:0] cd);
        case (cd)
            2'h2:    div_mask = 10'h03f;
            2'h3:    div_mask = 10'h3ff;
            default: div_mask = 10'h003;
        endcase
    endfunction : div_mask

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pmcd_pwr_type pwr_ff;
    pmcd_pwr_type nxt_pwr;
    logic [1:0]   cd_field_ff;
    logic [1:0]   cd_cur_ff;
    logic         sb_en_ff;
    logic         xoff_ff;
    logic         osel_ff;
    logic         osc_use_ff;
    logic         xrdy_ff;
    logic [3:0]   ext_cnt_ff;
    logic [9:0]   wdt_cnt_ff;
    logic         wdt_irq_ff;
    logic [9:0]   div_cnt_ff;
    logic         rx_prev_ff;
    logic         sys_rst_ff;
    logic [7:0]   rdata_ff;
    logic         core_en_ff;
    logic         mc_tick_ff;
    logic         per_tick_ff;
    logic         ale_ff;
    logic         pstore_ff;
    logic         hold_ff;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire       wr_pctl  = reg_wr && (reg_addr == PMCD_PCTL_OFF);
    wire       wr_pmgt  = reg_wr && (reg_addr == PMCD_PMGT_OFF);
    wire       wr_exfl  = reg_wr && (reg_addr == PMCD_EXFL_OFF);
    wire [1:0] wr_cd    = reg_wdata[PMCD_CD_HI_BIT:PMCD_CD_LO_BIT];
    wire       is_idle  = (pwr_ff == PMCD_IDLE);

    wire ext_hit = ext_rst_pin && (ext_cnt_ff == 4'(PMCD_EXT_RST_CLKS - 1));
    // time-out left uncleared for 512 clocks
    wire wdt_hit = wdt_irq_ff && !wdt_clear
                   && (wdt_cnt_ff == 10'(PMCD_WDT_RST_CLKS - 1));
    wire int_rst = ext_hit || wdt_hit;
    // all reset sources share one clear
    wire clr     = !rst_n || int_rst;

    // start bit edge, buffer write or external interrupt acknowledge
    wire rx_fall = ser.rx_enable && rx_prev_ff && !ser.rx_line;
    wire sb_trig = sb_en_ff && (rx_fall || ser.tx_buf_write || ext_int_ack);
    wire cd_ok   = wr_pmgt && (wr_cd != PMCD_CD_RSVD) && !(sb_en_ff && ser.busy);
    wire osel_ok = wr_exfl && (!reg_wdata[PMCD_OSEL_BIT] || xrdy_ff);

    wire [9:0] mask_cur = div_mask(cd_cur_ff);
    wire       mc_w     = ((div_cnt_ff & mask_cur) == mask_cur);
    wire       per_w    = is_idle ? ((div_cnt_ff & div_mask(PMCD_CD_DIV4))
                                     == div_mask(PMCD_CD_DIV4)) : mc_w;

    wire [7:0] rd_mux =
        (reg_addr == PMCD_PCTL_OFF) ? {7'h00, is_idle} :
        (reg_addr == PMCD_PMGT_OFF) ? {cd_field_ff, sb_en_ff, 1'b0, xoff_ff, 3'h0} :
        (reg_addr == PMCD_EXFL_OFF) ? {4'h0, osel_ff, osc_use_ff, 2'h0} :
        (reg_addr == PMCD_STAT_OFF) ? {3'h0, xrdy_ff, 4'h0} : 8'h00;

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    always_comb begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            // the writing instruction is the last one run
            PMCD_RUN:  if (wr_pctl && reg_wdata[PMCD_IDLE_BIT]) begin
                nxt_pwr = PMCD_IDLE;
            end
            // interrupt wake clears the idle bit
            PMCD_IDLE: if (irq_wake) begin
                nxt_pwr = PMCD_RUN;
            end
            default:   nxt_pwr = PMCD_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        // reset leaves idle with the core held, so nothing after it runs
        if (clr) begin
            pwr_ff <= PMCD_RUN;
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end

    // ------------------------------------------------------------
    // divider and control fields
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (clr) begin
            cd_field_ff <= PMCD_CD_RST;
            cd_cur_ff   <= PMCD_CD_RST;
            sb_en_ff    <= PMCD_SB_EN_RST;
            xoff_ff     <= PMCD_XOFF_RST;
            osel_ff     <= PMCD_OSEL_RST;
            osc_use_ff  <= PMCD_OSEL_RST;
            div_cnt_ff  <= 10'h000;
        end else begin
            div_cnt_ff <= div_cnt_ff + 10'h001;
            if (wr_pmgt) begin
                sb_en_ff <= reg_wdata[PMCD_SB_EN_BIT];
                xoff_ff  <= reg_wdata[PMCD_XOFF_BIT];
            end
            if (sb_trig) begin
                cd_field_ff <= PMCD_CD_DIV4;
            end else if (cd_ok) begin
                cd_field_ff <= wr_cd;
            end
            // field applied on next machine cycle boundary
            if (sb_trig) begin
                cd_cur_ff <= PMCD_CD_DIV4;
            end else if (mc_w) begin
                cd_cur_ff <= cd_field_ff;
            end
            if (osel_ok) begin
                osel_ff <= reg_wdata[PMCD_OSEL_BIT];
            end
            // source change applied one machine cycle later
            if (mc_w) begin
                osc_use_ff <= osel_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // reset sources and watchdog follow-up
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ext_cnt_ff <= 4'h0;
            wdt_cnt_ff <= 10'h000;
            wdt_irq_ff <= 1'b0;
            xrdy_ff    <= 1'b0;
            rx_prev_ff <= 1'b1;
            sys_rst_ff <= 1'b1;
        end else begin
            // count saturates so a long pin pulse keeps reset asserted
            if (!ext_rst_pin) begin
                ext_cnt_ff <= 4'h0;
            end else if (!ext_hit) begin
                ext_cnt_ff <= ext_cnt_ff + 4'h1;
            end
            // set wins over clear in the same cycle
            if (wdt_timeout) begin
                wdt_irq_ff <= 1'b1;
                wdt_cnt_ff <= 10'h000;
            end else if (wdt_clear || wdt_hit) begin
                wdt_irq_ff <= 1'b0;
                wdt_cnt_ff <= 10'h000;
            end else if (wdt_irq_ff) begin
                wdt_cnt_ff <= wdt_cnt_ff + 10'h001;
            end
            // ready drops once the amplifier is off
            xrdy_ff    <= crystal_warm && !xoff_ff;
            rx_prev_ff <= ser.rx_line;
            // restart at once, no added delay
            sys_rst_ff <= int_rst;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (clr) begin
            rdata_ff    <= 8'h00;
            core_en_ff  <= 1'b0;
            mc_tick_ff  <= 1'b0;
            per_tick_ff <= 1'b0;
            ale_ff      <= 1'b1;
            pstore_ff   <= 1'b1;
            hold_ff     <= 1'b0;
        end else begin
            rdata_ff    <= reg_rd ? rd_mux : 8'h00;
            core_en_ff  <= (nxt_pwr == PMCD_RUN);
            mc_tick_ff  <= mc_w;
            // idle peripherals at clock over four
            per_tick_ff <= per_w;
            // strobes high and ports frozen in idle
            ale_ff      <= (nxt_pwr == PMCD_IDLE) || ale_core;
            pstore_ff   <= (nxt_pwr == PMCD_IDLE) || pstore_core;
            hold_ff     <= (nxt_pwr == PMCD_IDLE);
        end
    end

    assign reg_rdata            = rdata_ff;
    assign core_clk_en          = core_en_ff;
    assign mc_tick              = mc_tick_ff;
    assign periph_tick          = per_tick_ff;
    assign addr_latch_strobe    = ale_ff;
    assign program_store_strobe = pstore_ff;
    assign port_hold            = hold_ff;
    assign osc_xtal_active      = osc_use_ff;
    assign crystal_amp_disable  = xoff_ff;
    assign wdt_irq              = wdt_irq_ff;
    assign sys_rst              = sys_rst_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_idle_entry_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_pctl && reg_wdata[0] && !is_idle && !int_rst) |=> is_idle && !core_clk_en)
        else $error("idle not entered after idle write");
    a_idle_core_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        (is_idle && !irq_wake && !int_rst) |=> !core_clk_en)
        else $error("core enabled during idle");
    a_idle_periph_tick: assert property (@(posedge mclk) disable iff (!rst_n)
        (is_idle && !int_rst) [*4] |=> periph_tick || $past(periph_tick)
            || $past(periph_tick, 2) || $past(periph_tick, 3))
        else $error("peripheral tick missing during idle");
    a_idle_strobes_high: assert property (@(posedge mclk) disable iff (!rst_n)
        (is_idle && !irq_wake && !int_rst) |=> addr_latch_strobe && program_store_strobe && port_hold)
        else $error("strobes not high in idle");
    a_irq_wake_exit: assert property (@(posedge mclk) disable iff (!rst_n)
        (is_idle && irq_wake && !int_rst) |=> !is_idle && core_clk_en)
        else $error("interrupt did not end idle");
    a_ext_reset_len: assert property (@(posedge mclk) disable iff (!rst_n)
        ext_rst_pin [*8] |=> sys_rst)
        else $error("external reset not recognised after eight clocks");
    a_wdt_reset_delay: assert property (@(posedge mclk) disable iff (!rst_n)
        (wdt_irq && wdt_cnt_ff == 10'h1ff && !wdt_clear && !wdt_timeout) |=> sys_rst)
        else $error("watchdog reset missing after 512 clocks");
    a_reset_div_four: assert property (@(posedge mclk) disable iff (!rst_n)
        sys_rst |-> (cd_cur_ff == PMCD_CD_DIV4) && !is_idle)
        else $error("reset did not restore divide by four");
    a_switchback_div: assert property (@(posedge mclk) disable iff (!rst_n)
        (sb_trig && !int_rst) |=> (cd_cur_ff == PMCD_CD_DIV4) && (cd_field_ff == PMCD_CD_DIV4))
        else $error("switchback did not force divide by four");
    a_busy_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_pmgt && sb_en_ff && ser.busy && !sb_trig && !int_rst) |=> $stable(cd_field_ff))
        else $error("divide field changed while serial busy");
    a_reserved_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_pmgt && wr_cd == PMCD_CD_RSVD && !sb_trig && !int_rst) |=> $stable(cd_field_ff))
        else $error("reserved divide code accepted");
    a_crystal_refused: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_exfl && reg_wdata[3] && !xrdy_ff && !osel_ff && !int_rst) |=> !osel_ff)
        else $error("crystal selected before ready");
    a_divide_delay: assert property (@(posedge mclk) disable iff (!rst_n)
        (!mc_w && !sb_trig && !int_rst) |=> $stable(cd_cur_ff))
        else $error("divide changed off a machine cycle boundary");

endmodule : pmcd_top
`default_nettype wire

// File: pmcd_pkg.sv
// constants and types for the power mode and clock divider block
package pmcd_pkg;

    // register offsets
    localparam logic [7:0] PMCD_PCTL_OFF   = 8'h00;
    localparam logic [7:0] PMCD_PMGT_OFF   = 8'h01;
    localparam logic [7:0] PMCD_EXFL_OFF   = 8'h02;
    localparam logic [7:0] PMCD_STAT_OFF   = 8'h03;

    // field positions
    localparam int PMCD_IDLE_BIT    = 0;
    localparam int PMCD_CD_LO_BIT   = 6;
    localparam int PMCD_CD_HI_BIT   = 7;
    localparam int PMCD_SB_EN_BIT   = 5;
    localparam int PMCD_XOFF_BIT    = 3;
    localparam int PMCD_OSEL_BIT    = 3;
    localparam int PMCD_OIND_BIT    = 2;
    localparam int PMCD_XRDY_BIT    = 4;

    // reset values
    localparam logic [1:0] PMCD_CD_RST     = 2'h1;
    localparam logic       PMCD_SB_EN_RST  = 1'b0;
    localparam logic       PMCD_XOFF_RST   = 1'b0;
    localparam logic       PMCD_OSEL_RST   = 1'b1;

    // timing counts in clock periods
    localparam int PMCD_EXT_RST_CLKS = 8;
    localparam int PMCD_WDT_RST_CLKS = 512;

    // divide codes
    localparam logic [1:0] PMCD_CD_RSVD = 2'h0;
    localparam logic [1:0] PMCD_CD_DIV4 = 2'h1;

    typedef enum logic [1:0] {
        PMCD_RUN  = 2'b01,
        PMCD_IDLE = 2'b10
    } pmcd_pwr_type;

    // serial port activity seen by the switchback logic
    typedef struct packed {
        logic rx_enable;
        logic rx_line;
        logic tx_buf_write;
        logic busy;
    } pmcd_serial_type;

endpackage : pmcd_pkg

// File: tb_pmcd_top.sv
// self-checking bench for the power mode and clock divider block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_pmcd_top;
    import pmcd_pkg::*;
    logic            mclk, rst_n, reg_wr, reg_rd, ext_rst_pin, irq_wake, ext_int_ack;
    logic            wdt_timeout, wdt_clear, crystal_warm, ale_core, pstore_core;
    logic [7:0]      reg_addr, reg_wdata, reg_rdata, d;
    pmcd_serial_type ser;
    logic            core_clk_en, mc_tick, periph_tick, addr_latch_strobe, port_hold;
    logic            program_store_strobe, osc_xtal_active, crystal_amp_disable;
    logic            wdt_irq, sys_rst;
    int              n_fail = 0;
    int              n_checks = 0;
    int              n;
    bit              s;

    pmcd_top pmcd_top_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_rst_pin(ext_rst_pin), .irq_wake(irq_wake), .ext_int_ack(ext_int_ack),
        .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear), .crystal_warm(crystal_warm),
        .ser(ser), .ale_core(ale_core), .pstore_core(pstore_core), .core_clk_en(core_clk_en),
        .mc_tick(mc_tick), .periph_tick(periph_tick), .addr_latch_strobe(addr_latch_strobe),
        .program_store_strobe(program_store_strobe), .port_hold(port_hold),
        .osc_xtal_active(osc_xtal_active), .crystal_amp_disable(crystal_amp_disable),
        .wdt_irq(wdt_irq), .sys_rst(sys_rst));

    // ------------------------------------------------------------
    // bus and timing tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc

    // cycles between two ticks; bounded so a dead divider cannot hang
    task automatic meas(input bit p, output int m);
        int k;
        k = 0;
        while (((p ? periph_tick : mc_tick) !== 1'b1) && k < 3000) begin
            @(posedge mclk);
            #1;
            k++;
        end
        m = 0;
        do begin
            @(posedge mclk);
            #1;
            m++;
        end while (((p ? periph_tick : mc_tick) !== 1'b1) && m < 3000);
    endtask : meas

    task automatic watch(input int len, output bit seen);
        seen = 1'b0;
        repeat (len) begin
            #1;
            seen |= (sys_rst === 1'b1);
            @(posedge mclk);
        end
    endtask : watch

    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        #400000;
        n_fail++;
        summarize();
    end

    initial begin
        {rst_n, reg_wr, reg_rd, ext_rst_pin, irq_wake, ext_int_ack} = '0;
        {wdt_timeout, wdt_clear, ale_core, pstore_core} = '0;
        {reg_addr, reg_wdata} = '0;
        crystal_warm = 1'b1;
        ser = 4'h4;
        cyc(2);
        #1;
        `CHK({sys_rst, addr_latch_strobe, program_store_strobe}, 3'b111)
        cyc(1);
        rst_n <= 1'b1;
        rd(PMCD_PMGT_OFF, d); `CHK(d, 8'h40)
        rd(PMCD_EXFL_OFF, d); `CHK(d, 8'h0c)
        rd(PMCD_STAT_OFF, d); `CHK(d[4], 1'b1)
        rd(8'h07, d); `CHK(d, 8'h00)
        meas(0, n); meas(0, n); `CHK(n, 4)
        wr(PMCD_PMGT_OFF, 8'h80);
        meas(0, n); meas(0, n); `CHK(n, 64)
        meas(1, n); meas(1, n); `CHK(n, 64)
        wr(PMCD_PMGT_OFF, 8'h00);
        rd(PMCD_PMGT_OFF, d); `CHK(d, 8'h80)
        meas(0, n); meas(0, n); `CHK(n, 64)
        // idle entry freezes the core but not the peripherals
        wr(PMCD_PCTL_OFF, 8'h01);
        cyc(2);
        #1;
        `CHK({core_clk_en, addr_latch_strobe, program_store_strobe, port_hold}, 4'h7)
        meas(1, n); meas(1, n); `CHK(n, 4)
        rd(PMCD_PCTL_OFF, d); `CHK(d, 8'h01)
        @(posedge mclk);
        irq_wake <= 1'b1;
        cyc(3);
        irq_wake <= 1'b0;
        #1;
        `CHK(core_clk_en, 1'b1)
        `CHK({addr_latch_strobe, program_store_strobe, port_hold}, 3'b000)
        rd(PMCD_PCTL_OFF, d); `CHK(d, 8'h00)
        // slow rates are reached through divide by four
        wr(PMCD_PMGT_OFF, 8'h40);
        meas(0, n);
        meas(0, n);
        `CHK(n, 4)
        wr(PMCD_PMGT_OFF, 8'hc0);
        meas(0, n); meas(0, n); `CHK(n, 1024)
        // back to divide by four before the next slow rate
        wr(PMCD_PMGT_OFF, 8'h40);
        meas(0, n);
        meas(0, n);
        `CHK(n, 4)
        @(posedge mclk);
        ser <= 4'hc;
        for (int k = 0; k < 3; k++) begin
            wr(PMCD_PMGT_OFF, 8'ha0);
            cyc(4);
            case (k)
                0: ser.tx_buf_write <= 1'b1;
                1: ser.rx_line <= 1'b0;
                default: ext_int_ack <= 1'b1;
            endcase
            @(posedge mclk);
            ser         <= 4'hc;
            ext_int_ack <= 1'b0;
            rd(PMCD_PMGT_OFF, d); `CHK(d, 8'h60)
        end
        meas(0, n); meas(0, n); `CHK(n, 4)
        @(posedge mclk);
        ser <= 4'hd;
        wr(PMCD_PMGT_OFF, 8'ha0);
        rd(PMCD_PMGT_OFF, d); `CHK(d[7:6], 2'b01)
        @(posedge mclk);
        ser <= 4'h4;
        // oscillator source, amplifier and ready gating
        wr(PMCD_EXFL_OFF, 8'h00);
        cyc(8);
        rd(PMCD_EXFL_OFF, d); `CHK(d, 8'h00)
        `CHK(osc_xtal_active, 1'b0)
        wr(PMCD_PMGT_OFF, 8'h48);
        rd(PMCD_STAT_OFF, d); `CHK({crystal_amp_disable, d[4]}, 2'b10)
        wr(PMCD_PMGT_OFF, 8'h40);
        crystal_warm <= 1'b0;
        wr(PMCD_EXFL_OFF, 8'h08);
        cyc(8);
        rd(PMCD_EXFL_OFF, d); `CHK(d, 8'h00)
        @(posedge mclk);
        crystal_warm <= 1'b1;
        cyc(2);
        wr(PMCD_EXFL_OFF, 8'h08);
        cyc(8);
        rd(PMCD_EXFL_OFF, d); `CHK(d, 8'h0c)
        // external reset needs eight clocks of pin high
        wr(PMCD_PMGT_OFF, 8'h80);
        @(posedge mclk);
        ext_rst_pin <= 1'b1;
        cyc(7);
        ext_rst_pin <= 1'b0;
        watch(10, s); `CHK(s, 1'b0)
        // the valid pulse is taken from idle
        wr(PMCD_PCTL_OFF, 8'h01);
        ext_rst_pin <= 1'b1;
        cyc(8);
        ext_rst_pin <= 1'b0;
        watch(4, s); `CHK(s, 1'b1)
        cyc(2);
        rd(PMCD_PMGT_OFF, d); `CHK(d, 8'h40)
        rd(PMCD_PCTL_OFF, d);
        `CHK(d, 8'h00)
        `CHK(core_clk_en, 1'b1)
        // watchdog interrupt then reset unless restarted
        wr(PMCD_PMGT_OFF, 8'h80);
        @(posedge mclk);
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
        #1;
        `CHK(wdt_irq, 1'b1)
        n = 0;
        while (sys_rst !== 1'b1 && n < 600) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK(n >= 511 && n <= 515, 1'b1)
        cyc(3);
        rd(PMCD_PMGT_OFF, d); `CHK(d, 8'h40)
        @(posedge mclk);
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
        cyc(20);
        wdt_clear <= 1'b1;
        @(posedge mclk);
        wdt_clear <= 1'b0;
        watch(600, s); `CHK(s, 1'b0)
        // power-on reset restores divide by four
        wr(PMCD_PMGT_OFF, 8'h80);
        @(posedge mclk);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        rd(PMCD_PMGT_OFF, d); `CHK(d, 8'h40)
        summarize();
    end
endmodule : tb_pmcd_top
`default_nettype wire
